// *** design/elos_regs.svh ***
`ifndef ELOS_REGS_SVH
`define ELOS_REGS_SVH
`define ELOS_ADDR_CTRL 12'h000
`define ELOS_ADDR_DETECT 12'h004
`define ELOS_ADDR_RECOVER 12'h008
`define ELOS_ADDR_STATUS 12'h00C
`define ELOS_ADDR_IRQ 12'h010
`define ELOS_ADDR_MASK 12'h014
`define ELOS_CTRL_RESET 32'h0000_0000
`define ELOS_DETECT_RESET 8'hFF
`define ELOS_RECOVER_RESET 8'h0F
`define ELOS_MASK_RESET 1'h1
`define ELOS_B_SCI 0
`define ELOS_B_DRS 1
`define ELOS_B_EQON 2
`define ELOS_B_MAS 3
`define ELOS_B_SCF 4
`define ELOS_B_DJA 5
`define ELOS_B_CSC 6
`define ELOS_B_FSC_EN 7
`define ELOS_B_LVL_REC 8
`define ELOS_F_RIL_LO 9
`define ELOS_F_RIL_HI 11
`define ELOS_NS_2M 488
`define ELOS_CLK_NS 4
`define ELOS_MISS_CYC (2 * `ELOS_NS_2M / `ELOS_CLK_NS)
`define ELOS_FRAME_DIV 256
`endif

// *** design/elos_pkg.sv ***
package elos_pkg;
    typedef enum logic [1:0] {
        ELOS_REF_LINE,
        ELOS_REF_SYNC,
        ELOS_REF_FREE
    } elos_ref_t;
    typedef enum logic {
        ELOS_S_OK,
        ELOS_S_LOST
    } elos_state_t;
endpackage

// *** design/elos_top.sv ***
`timescale 1ns/100ps
`include "elos_regs.svh"
module elos_top
    import elos_pkg::*;
#(
    parameter int PHASE_W = 32,
    parameter logic [31:0] NOMINAL_STEP = 32'h0863_0000
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_dual_rail_pos,
    input wire logic rx_dual_rail_neg,
    input wire logic rx_optical_data,
    input wire logic rx_pulse_analog,
    input wire logic [2:0] rx_pulse_level,
    input wire logic eq_signal_ok,
    input wire logic eq_level_low,
    input wire logic rx_clock_input,
    input wire logic sync_input,
    input wire logic rx_data_in,
    output logic rx_data_out,
    output logic loss_status,
    output logic loss_irq,
    output logic dejittered_sys_clock,
    output logic frame_sync_clock,
    output logic sys_16m_clock_out,
    output logic sys_rx_clock,
    output logic [1:0] osc_ref_sel,
    output logic osc_corner_low
);
    logic [31:0] ctrl_reg;
    logic [7:0] loss_detect_count_reg;
    logic [7:0] loss_recover_count_reg;
    logic irq_reg;
    logic mask_reg;
    logic [2:0] pos_sync_reg, neg_sync_reg, opt_sync_reg, ana_sync_reg;
    logic [2:0] rck_sync_reg, syn_sync_reg;
    logic [1:0] low_sync_reg, eq_sync_reg;
    logic [2:0] lvl_a_reg, lvl_b_reg;
    logic [11:0] idle_cnt_reg;
    logic [7:0] rec_cnt_reg;
    elos_state_t state_reg;
    logic lvl_armed_reg;
    logic [7:0] rck_miss_reg, syn_miss_reg;
    logic [PHASE_W-1:0] phase_reg;
    logic [8:0] frame_cnt_reg;
    logic data_out_reg;
    logic fsc_reg;

    function automatic logic rise(input logic [2:0] s);
        return s[1] & ~s[2];
    endfunction

    function automatic logic [7:0] miss_next(input logic [7:0] m,
                                             input logic edge_seen);
        if (edge_seen) begin
            return 8'h00;
        end
        return (m == 8'hFF) ? m : m + 8'h01;
    endfunction

    wire logic sel_sci = ctrl_reg[`ELOS_B_SCI];
    wire logic digital_rx_select = ctrl_reg[`ELOS_B_DRS];
    wire logic long_haul_enable = ctrl_reg[`ELOS_B_EQON];
    wire logic osc_master_select = ctrl_reg[`ELOS_B_MAS];
    wire logic corner_freq_select = ctrl_reg[`ELOS_B_SCF];
    wire logic crystalless_select = ctrl_reg[`ELOS_B_DJA];
    wire logic sys_clock_source_sel = ctrl_reg[`ELOS_B_CSC];
    wire logic fsc_enable = ctrl_reg[`ELOS_B_FSC_EN];
    wire logic level_recover_req = ctrl_reg[`ELOS_B_LVL_REC];
    wire logic [2:0] rx_level_threshold =
        ctrl_reg[`ELOS_F_RIL_HI:`ELOS_F_RIL_LO];

    // Input pins except rx_data_in pass two flip-flops; the third stage of the rck and syn chains is for edge detect.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pos_sync_reg <= 3'h0;
            neg_sync_reg <= 3'h0;
            opt_sync_reg <= 3'h0;
            ana_sync_reg <= 3'h0;
            rck_sync_reg <= 3'h0;
            syn_sync_reg <= 3'h0;
            low_sync_reg <= 2'h0;
            eq_sync_reg <= 2'h0;
            lvl_a_reg <= 3'h0;
            lvl_b_reg <= 3'h0;
        end else begin
            pos_sync_reg <= {pos_sync_reg[1:0], rx_dual_rail_pos};
            neg_sync_reg <= {neg_sync_reg[1:0], rx_dual_rail_neg};
            opt_sync_reg <= {opt_sync_reg[1:0], rx_optical_data};
            ana_sync_reg <= {ana_sync_reg[1:0], rx_pulse_analog};
            rck_sync_reg <= {rck_sync_reg[1:0], rx_clock_input};
            syn_sync_reg <= {syn_sync_reg[1:0], sync_input};
            low_sync_reg <= {low_sync_reg[0], eq_level_low};
            eq_sync_reg <= {eq_sync_reg[0], eq_signal_ok};
            lvl_a_reg <= rx_pulse_level;
            lvl_b_reg <= lvl_a_reg;
        end
    end

    // One decision per rising edge of the recovered clock.
    logic period_tick;
    logic pulse_seen;
    logic level_low;
    assign period_tick = rise(rck_sync_reg);
    assign level_low = long_haul_enable & ~digital_rx_select
        & low_sync_reg[1];
    always_comb begin
        if (digital_rx_select) begin
            pulse_seen = pos_sync_reg[1] | neg_sync_reg[1]
                | opt_sync_reg[1];
        end else if (long_haul_enable) begin
            pulse_seen = ana_sync_reg[1] & eq_sync_reg[1];
        end else begin
            pulse_seen = ana_sync_reg[1]
                & (lvl_b_reg >= rx_level_threshold);
        end
    end

    logic [11:0] detect_n;
    assign detect_n = {loss_detect_count_reg, 4'h0};
    logic idle_full;
    assign idle_full = (idle_cnt_reg + 12'h001 >= detect_n)
        && detect_n != 12'h000;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_cnt_reg <= 12'h000;
        end else if (period_tick) begin
            if (pulse_seen || idle_full) begin
                idle_cnt_reg <= 12'h000;
            end else begin
                idle_cnt_reg <= idle_cnt_reg + 12'h001;
            end
        end
    end

    logic rec_ok;
    assign rec_ok = (loss_recover_count_reg == 8'h00)
        || (rec_cnt_reg + 8'h01 >= loss_recover_count_reg);
    logic lvl_gate;
    assign lvl_gate = ~low_sync_reg[1] | ~level_recover_req;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ELOS_S_OK;
            rec_cnt_reg <= 8'h00;
            lvl_armed_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ELOS_S_OK: begin
                    rec_cnt_reg <= 8'h00;
                    lvl_armed_reg <= 1'b0;
                    if (level_low) begin
                        state_reg <= ELOS_S_LOST;
                    end else if (period_tick && !pulse_seen && idle_full) begin
                        state_reg <= ELOS_S_LOST;
                    end
                end
                ELOS_S_LOST: begin
                    if (long_haul_enable && !digital_rx_select
                        && !lvl_armed_reg) begin
                        lvl_armed_reg <= ~low_sync_reg[1];
                        rec_cnt_reg <= 8'h00;
                    end else if (period_tick) begin
                        if (pulse_seen && lvl_gate) begin
                            if (rec_ok) begin
                                state_reg <= ELOS_S_OK;
                            end else begin
                                rec_cnt_reg <= rec_cnt_reg + 8'h01;
                            end
                        end else if (idle_full) begin
                            rec_cnt_reg <= 8'h00;
                        end
                    end
                    if (level_low) begin
                        lvl_armed_reg <= 1'b0;
                    end
                end
            endcase
        end
    end

    logic lost;
    assign lost = (state_reg == ELOS_S_LOST);
    logic lost_d_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lost_d_reg <= 1'b0;
        end else begin
            lost_d_reg <= lost;
        end
    end

    logic irq_event;
    assign irq_event = sel_sci ? (lost ^ lost_d_reg)
        : (lost & ~lost_d_reg);

    // APB slave, zero wait states.
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign pready = 1'b1;
    always_comb begin
        unique case (paddr)
            `ELOS_ADDR_CTRL, `ELOS_ADDR_DETECT, `ELOS_ADDR_RECOVER,
            `ELOS_ADDR_STATUS, `ELOS_ADDR_IRQ, `ELOS_ADDR_MASK:
                addr_ok = 1'b1;
            default:
                addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~addr_ok;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= `ELOS_CTRL_RESET;
            loss_detect_count_reg <= `ELOS_DETECT_RESET;
            loss_recover_count_reg <= `ELOS_RECOVER_RESET;
            mask_reg <= `ELOS_MASK_RESET;
        end else if (wr_en) begin
            unique case (paddr)
                `ELOS_ADDR_CTRL: ctrl_reg <= {20'h00000, pwdata[11:0]};
                `ELOS_ADDR_DETECT: loss_detect_count_reg <= pwdata[7:0];
                `ELOS_ADDR_RECOVER: loss_recover_count_reg <= pwdata[7:0];
                `ELOS_ADDR_MASK: mask_reg <= pwdata[0];
                default: ;
            endcase
        end
    end

    // Write one to clear; a new event in the same cycle wins.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_reg <= 1'b0;
        end else if (irq_event) begin
            irq_reg <= 1'b1;
        end else if (wr_en && paddr == `ELOS_ADDR_IRQ && pwdata[0]) begin
            irq_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `ELOS_ADDR_CTRL: prdata <= ctrl_reg;
                `ELOS_ADDR_DETECT:
                    prdata <= {24'h000000, loss_detect_count_reg};
                `ELOS_ADDR_RECOVER:
                    prdata <= {24'h000000, loss_recover_count_reg};
                `ELOS_ADDR_STATUS: prdata <= {30'h0, lvl_armed_reg, lost};
                `ELOS_ADDR_IRQ: prdata <= {31'h0, irq_reg};
                `ELOS_ADDR_MASK: prdata <= {31'h0, mask_reg};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
    assign loss_status = lost;
    assign loss_irq = irq_reg & ~mask_reg;

    // Reference watchdogs: missing edges for two 2.048 MHz periods.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rck_miss_reg <= 8'hFF;
            syn_miss_reg <= 8'hFF;
        end else begin
            rck_miss_reg <= miss_next(rck_miss_reg, rise(rck_sync_reg));
            syn_miss_reg <= miss_next(syn_miss_reg, rise(syn_sync_reg));
        end
    end
    logic rck_present;
    logic syn_present;
    assign rck_present = rck_miss_reg < 8'(`ELOS_MISS_CYC);
    assign syn_present = syn_miss_reg < 8'(`ELOS_MISS_CYC);

    elos_ref_t ref_sel;
    always_comb begin
        if (!osc_master_select && !lost && rck_present) begin
            ref_sel = ELOS_REF_LINE;
        end else if (syn_present) begin
            ref_sel = ELOS_REF_SYNC;
        end else begin
            ref_sel = ELOS_REF_FREE;
        end
    end
    assign osc_ref_sel = ref_sel;
    assign osc_corner_low = corner_freq_select;

    // Phase accumulator: nominal step, nudged by the reference edge.
    logic ref_edge;
    assign ref_edge = (ref_sel == ELOS_REF_LINE) ? rise(rck_sync_reg)
        : (ref_sel == ELOS_REF_SYNC) ? rise(syn_sync_reg) : 1'b0;
    logic [PHASE_W-1:0] step;
    always_comb begin
        step = PHASE_W'(NOMINAL_STEP);
        if (ref_edge && phase_reg[PHASE_W-1]) begin
            step = step + PHASE_W'(corner_freq_select ? 32'h10 : 32'h100);
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_reg <= '0;
        end else if (ref_sel == ELOS_REF_FREE && !rck_present
                     && !syn_present) begin
            phase_reg <= phase_reg + PHASE_W'(NOMINAL_STEP);
        end else begin
            phase_reg <= phase_reg + step;
        end
    end

    logic osc_clk;
    logic osc_rise;
    logic osc_d_reg;
    assign osc_clk = phase_reg[PHASE_W-1];
    assign osc_rise = osc_clk & ~osc_d_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_d_reg <= 1'b0;
            frame_cnt_reg <= 9'h000;
            fsc_reg <= 1'b0;
        end else begin
            osc_d_reg <= osc_clk;
            if (osc_rise) begin
                if (frame_cnt_reg == 9'(`ELOS_FRAME_DIV - 1)) begin
                    frame_cnt_reg <= 9'h000;
                end else begin
                    frame_cnt_reg <= frame_cnt_reg + 9'h001;
                end
            end
            // One clock pulse as the frame count wraps.
            fsc_reg <= fsc_enable & osc_rise
                & (frame_cnt_reg == 9'(`ELOS_FRAME_DIV - 1));
        end
    end

    // Low level forces all-ones data before bit errors appear.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_out_reg <= 1'b1;
        end else begin
            data_out_reg <= level_low ? 1'b1 : rx_data_in;
        end
    end

    assign rx_data_out = data_out_reg;
    assign frame_sync_clock = fsc_reg;
    assign dejittered_sys_clock = osc_d_reg;
    assign sys_rx_clock = osc_d_reg;
    assign sys_16m_clock_out = (crystalless_select && !sys_clock_source_sel)
        ? rck_sync_reg[2] : osc_d_reg;
endmodule

// *** verification/elos_chk_sva.sv ***
`timescale 1ns/100ps
`include "elos_regs.svh"
module elos_chk
    import elos_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic eq_level_low,
    input wire logic sync_input,
    input wire logic rx_clock_input,
    input wire logic rx_data_out,
    input wire logic loss_status,
    input wire logic loss_irq,
    input wire logic frame_sync_clock,
    input wire logic [1:0] osc_ref_sel,
    input wire logic osc_corner_low
);
    logic [31:0] ctrl_reg;
    logic mask_reg;
    logic [9:0] idle_reg;
    logic [9:0] rck_idle_reg;
    logic wr;
    logic low_lvl;
    logic up;
    assign wr = psel && penable && pwrite;
    assign low_lvl = ctrl_reg[2] && !ctrl_reg[1] && eq_level_low;
    assign up = ctrl_reg[3] || loss_status;
    // Shadow copies of control and mask, updated with the block.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= 32'h0;
            mask_reg <= 1'b1;
        end else if (wr && paddr == `ELOS_ADDR_CTRL) begin
            ctrl_reg <= pwdata;
        end else if (wr && paddr == `ELOS_ADDR_MASK) begin
            mask_reg <= pwdata[0];
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_reg <= 10'h3FF;
        end else if ($changed(sync_input)) begin
            idle_reg <= 10'h000;
        end else if (idle_reg != 10'h3FF) begin
            idle_reg <= idle_reg + 10'h001;
        end
    end
    // Counts clocks since the line clock last moved.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rck_idle_reg <= 10'h3FF;
        end else if ($changed(rx_clock_input)) begin
            rck_idle_reg <= 10'h000;
        end else if (rck_idle_reg != 10'h3FF) begin
            rck_idle_reg <= rck_idle_reg + 10'h001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_irq_on_loss: assert property ($rose(loss_status) && !mask_reg
        |-> ##[0:2] loss_irq) else $error("no irq on loss");
    chk_irq_masked: assert property (mask_reg |-> !loss_irq)
        else $error("irq while masked");
    chk_irq_on_clear: assert property (ctrl_reg[0] && !mask_reg
        && $fell(loss_status) |-> ##[0:2] loss_irq) else $error("no irq");
    chk_low_forces_one: assert property (low_lvl [*4]
        |-> rx_data_out) else $error("data not forced");
    chk_low_gives_loss: assert property (low_lvl [*4]
        |-> loss_status) else $error("no loss on low level");
    chk_corner_follows: assert property (wr
        && paddr == `ELOS_ADDR_CTRL
        |=> osc_corner_low == $past(pwdata[4])) else $error("corner");
    chk_ref_line: assert property ((!up && rck_idle_reg < 10'h064) [*3]
        |-> osc_ref_sel == ELOS_REF_LINE) else $error("ref not line");
    chk_ref_free: assert property ((up && idle_reg > 10'h12C) [*3]
        |-> osc_ref_sel == ELOS_REF_FREE) else $error("ref not free");
    chk_ref_sync: assert property ((up && idle_reg > 10'h00F
        && idle_reg < 10'h03D) [*3] |-> osc_ref_sel == ELOS_REF_SYNC)
        else $error("ref not sync");
    chk_frame_pulse: assert property (frame_sync_clock
        |-> (ctrl_reg[7] || $past(ctrl_reg[7])) ##1 !frame_sync_clock)
        else $error("frame pulse");
    cover property ($rose(loss_status));
    cover property ($fell(loss_status));
    cover property (osc_ref_sel == ELOS_REF_SYNC);
endmodule

// *** verification/elos_line_model.sv ***
`timescale 1ns/100ps
module elos_line_model #(
    parameter int HALF = 61
) (
    input wire logic clk,
    input wire logic sync_run,
    input wire logic one,
    input wire logic [2:0] amp,
    output logic rx_clock_input,
    output logic sync_input,
    output logic rx_dual_rail_pos,
    output logic rx_dual_rail_neg,
    output logic rx_optical_data,
    output logic rx_pulse_analog,
    output logic [2:0] rx_pulse_level
);
    int cnt = 0;
    logic pol = 1'b0;
    initial begin
        rx_clock_input = 1'b0;
        sync_input = 1'b0;
        rx_dual_rail_pos = 1'b0;
        rx_dual_rail_neg = 1'b0;
        rx_optical_data = 1'b0;
        rx_pulse_analog = 1'b0;
        rx_pulse_level = 3'h0;
    end
    // Bits change on the falling line edge so each rise sees a settled bit.
    always @(posedge clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
            rx_clock_input <= !rx_clock_input;
            sync_input <= sync_run ? !sync_input : sync_input;
            if (rx_clock_input) begin
                pol <= pol ^ one;
                rx_dual_rail_pos <= one && !pol;
                rx_dual_rail_neg <= one && pol;
                rx_optical_data <= one;
                rx_pulse_analog <= one;
                rx_pulse_level <= one ? amp : 3'h0;
            end
        end
    end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
`include "elos_regs.svh"
module tb_top
    import elos_pkg::*;
;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic eq_signal_ok, eq_level_low, sync_run, one, rx_data_in, rx_data_out;
    logic rx_clock_input, sync_input, rx_dual_rail_pos, rx_dual_rail_neg;
    logic rx_optical_data, rx_pulse_analog, loss_status, loss_irq;
    logic frame_sync_clock, osc_corner_low;
    logic dejittered_sys_clock, sys_16m_clock_out;
    logic [2:0] amp, rx_pulse_level;
    logic [1:0] osc_ref_sel;
    logic [11:0] ra[5] = '{12'h000, 12'h004, 12'h008, 12'h014, 12'h018};
    logic [31:0] re[5] = '{32'h0, 32'hFF, 32'h0F, 32'h1, 32'h0};
    int num_errors = 0;
    int compares = 0;
    int n;
    elos_top uut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rx_dual_rail_pos, .rx_dual_rail_neg,
        .rx_optical_data, .rx_pulse_analog, .rx_pulse_level, .eq_signal_ok,
        .eq_level_low, .rx_clock_input, .sync_input, .rx_data_in,
        .rx_data_out, .loss_status, .loss_irq, .dejittered_sys_clock,
        .frame_sync_clock, .sys_16m_clock_out, .sys_rx_clock(),
        .osc_ref_sel, .osc_corner_low);
    elos_line_model line (.clk, .sync_run, .one, .amp, .rx_clock_input,
        .sync_input, .rx_dual_rail_pos, .rx_dual_rail_neg, .rx_optical_data,
        .rx_pulse_analog, .rx_pulse_level);
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 100);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Sets the bit sent from the next falling line edge and waits cnt rises.
    task automatic feed(input logic v, input int cnt);
        one <= v;
        repeat (cnt) @(posedge rx_clock_input);
        repeat (8) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        eq_signal_ok = 1'b1;
        eq_level_low = 1'b0;
        sync_run = 1'b0;
        one = 1'b1;
        amp = 3'h7;
        rx_data_in = 1'b0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        foreach (ra[i]) begin
            apb(ra[i], 1'b0, 32'h0);
            chk("reset value", re[i], rd);
        end
        chk("slave error", 1'h1, err);
        apb(`ELOS_ADDR_CTRL, 1'b1, 32'h3);
        apb(`ELOS_ADDR_DETECT, 1'b1, 32'h1);
        apb(`ELOS_ADDR_RECOVER, 1'b1, 32'h3);
        apb(`ELOS_ADDR_MASK, 1'b1, 32'h0);
        apb(`ELOS_ADDR_DETECT, 1'b0, 32'h0);
        chk("detect count", 32'h1, rd);
        $display("end of register test");
        feed(1'b1, 3);
        chk("loss", 1'h0, loss_status);
        feed(1'b0, 15);
        chk("loss", 1'h0, loss_status);
        feed(1'b0, 1);
        chk("loss", 1'h1, loss_status);
        chk("irq", 1'h1, loss_irq);
        chk("ref", ELOS_REF_FREE, osc_ref_sel);
        apb(`ELOS_ADDR_IRQ, 1'b1, 32'h1);
        chk("irq", 1'h0, loss_irq);
        feed(1'b1, 2);
        chk("loss", 1'h1, loss_status);
        feed(1'b0, 16);
        feed(1'b1, 2);
        chk("loss", 1'h1, loss_status);
        feed(1'b1, 1);
        chk("loss", 1'h0, loss_status);
        chk("irq", 1'h1, loss_irq);
        $display("end of digital test");
        apb(`ELOS_ADDR_CTRL, 1'b1, 32'h0A01);
        amp <= 3'h4;
        feed(1'b1, 16);
        chk("loss", 1'h1, loss_status);
        amp <= 3'h5;
        feed(1'b1, 3);
        chk("loss", 1'h0, loss_status);
        $display("end of short haul test");
        apb(`ELOS_ADDR_CTRL, 1'b1, 32'h0105);
        eq_level_low <= 1'b1;
        repeat (8) @(posedge clk);
        chk("loss", 1'h1, loss_status);
        chk("data", 1'h1, rx_data_out);
        feed(1'b1, 4);
        chk("loss", 1'h1, loss_status);
        eq_level_low <= 1'b0;
        feed(1'b1, 3);
        chk("loss", 1'h0, loss_status);
        chk("data", 1'h0, rx_data_out);
        $display("end of long haul test");
        apb(`ELOS_ADDR_CTRL, 1'b1, 32'h0098);
        sync_run <= 1'b1;
        repeat (300) @(posedge clk);
        chk("ref", ELOS_REF_SYNC, osc_ref_sel);
        chk("corner", 1'h1, osc_corner_low);
        sync_run <= 1'b0;
        repeat (300) @(posedge clk);
        chk("ref", ELOS_REF_FREE, osc_ref_sel);
        apb(`ELOS_ADDR_CTRL, 1'b1, 32'h0080);
        chk("ref", ELOS_REF_LINE, osc_ref_sel);
        n = 0;
        while (frame_sync_clock !== 1'b1 && n < 40000) begin
            @(posedge clk);
            n++;
        end
        chk("frame", 1'h1, frame_sync_clock);
        apb(`ELOS_ADDR_CTRL, 1'b1, 32'h0060);
        chk("clock16", dejittered_sys_clock, sys_16m_clock_out);
        $display("end of oscillator test");
        tally_and_finish();
    end
endmodule
bind elos_top elos_chk chk_i (.clk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .eq_level_low, .sync_input, .rx_clock_input,
    .rx_data_out, .loss_status,
    .loss_irq, .frame_sync_clock, .osc_ref_sel, .osc_corner_low);
